// ### hw/sdi_tx_formatter_scrambler.v
// sdi transmit formatter: HD line number and CRC insertion, scrambler, NRZI coder, two-entry output buffer
`timescale 1ns/1ps
`default_nettype none
`include "sdi_tx_consts.vh"

module sdi_tx_formatter_scrambler #(
	parameter RATE_SWITCH_EN = 0
) (
	// clock and reset
	input wire clk_sys,
	input wire reset_n,
	// mode
	input wire hd_mode,
	// video source stream
	input wire [19:0] video_in,
	input wire video_valid,
	input wire trs_marker,
	input wire [15:0] line_number_in,
	output reg video_ready_q,
	// coded stream to the serializer
	output reg [19:0] coded_out_q,
	output reg coded_valid_q,
	input wire coded_ready,
	// reference clock choice
	input wire alt_serial_ref_clock,
	input wire rate_family_sel,
	output reg ref_clock_select_q
);

	// advance an 18-bit CRC over one 10-bit channel word, lsb first
	function [17:0] crc_word;
		input [17:0] crc_in;
		input [9:0] w;
		reg [17:0] c;
		reg fb;
		integer i;
		begin
			c = crc_in;
			for (i = 0; i < 10; i = i + 1)
			begin
				fb = c[0] ^ w[i];
				c = {fb, c[17:1]};
				c[13] = c[13] ^ fb;
				c[12] = c[12] ^ fb;
			end
			crc_word = c; // see RQ11 see RQ12
		end
	endfunction

	// sdi ten-bit word format for inserted words: bit 9 is the inverse of bit 8
	function [9:0] anc_word;
		input [8:0] b;
		begin
			anc_word = {~b[8], b};
		end
	endfunction

	// scramble then NRZI code up to 20 bits lsb first; result {nrzi_last, lfsr, data}
	function [29:0] code_word;
		input [9:0] st;
		input [19:0] w;
		input wide;
		reg [8:0] s;
		reg p;
		reg sb;
		reg [19:0] o;
		integer i;
		begin
			s = st[8:0];
			p = st[9];
			o = 20'h00000;
			for (i = 0; i < 20; i = i + 1)
			begin
				if (wide || i < 10) // see RQ14
				begin
					sb = w[i] ^ s[8] ^ s[3];
					s = {s[7:0], sb};
					p = p ^ sb;
					o[i] = p;
				end
			end
			code_word = {p, s, o}; // see RQ13 see RQ15
		end
	endfunction

	// reset release: assertion is immediate, release waits for two clean edges
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n = rst_s2_q;

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// timing reference tracking
	reg [2:0] seq_q;
	reg eav_q;
	reg crc_run_q;
	reg [17:0] luma_crc_q;
	reg [17:0] chroma_crc_q;
	reg [9:0] scr_q;
	wire accept = video_valid & video_ready_q;

	// line number words, same for both channels
	// upper line-number bits are ignored, the field is 11 bits in the stream
	wire [10:0] ln = line_number_in[10:0]; // see RQ4
	wire [9:0] line_word_first = anc_word({ln[6:0], 2'b00});
	wire [9:0] line_word_second = anc_word({3'b000, ln[10:7], 2'b00});
	wire [9:0] luma_crc_word_first = anc_word(luma_crc_q[8:0]); // see RQ17
	wire [9:0] luma_crc_word_second = anc_word(luma_crc_q[17:9]);
	wire [9:0] chroma_crc_word_first = anc_word(chroma_crc_q[8:0]);
	wire [9:0] chroma_crc_word_second = anc_word(chroma_crc_q[17:9]);

	// formatted word; insertion only in HD and only after an EAV
	reg [19:0] fmt;
	// 3G level B takes the HD path; its two links are not told apart
	wire ins = hd_mode & eav_q & ~trs_marker; // see RQ18 see RQ3

	always @*
	begin
		fmt = hd_mode ? video_in : {10'h000, video_in[9:0]}; // see RQ1 see RQ2
		if (ins)
		begin
			if (seq_q == `SEQ_LINE_FIRST)
				fmt = {line_word_first, line_word_first}; // see RQ5 see RQ6
			else if (seq_q == `SEQ_LINE_SECOND)
				fmt = {line_word_second, line_word_second};
			else if (seq_q == `SEQ_CRC_FIRST)
				fmt = {luma_crc_word_first, chroma_crc_word_first}; // see RQ8
			else if (seq_q == `SEQ_CRC_SECOND)
				fmt = {luma_crc_word_second, chroma_crc_word_second};
		end
	end

	// one combinational pass per word, 20 bit steps deep: the long path of the block
	wire [29:0] coded = code_word(scr_q, fmt, hd_mode);

	// sequence position relies on the source flagging every EAV and SAV first word
	// a missed EAV marker leaves seq_q idle and that line goes out without insertion
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_q <= `SEQ_IDLE;
			eav_q <= 1'b0;
			crc_run_q <= 1'b0;
			luma_crc_q <= `CRC_ZERO;
			chroma_crc_q <= `CRC_ZERO;
			scr_q <= {1'b0, `SCR_ZERO};
		end
		else if (accept)
		begin
			// coder state carries across words, also across a mode change
			scr_q <= coded[29:20];
			if (trs_marker) // see RQ7
				seq_q <= 3'h1;
			else if (seq_q != `SEQ_IDLE && seq_q != `SEQ_CRC_SECOND)
				seq_q <= seq_q + 3'h1;
			else
				seq_q <= `SEQ_IDLE;
			if (!trs_marker && seq_q == `SEQ_XYZ)
				eav_q <= video_in[`XYZ_H_BIT];
			else if (trs_marker)
				eav_q <= 1'b0;
			// an SAV XYZ word restarts both CRCs; counting begins with the next word
			if (!trs_marker && seq_q == `SEQ_XYZ && !video_in[`XYZ_H_BIT])
			begin
				crc_run_q <= 1'b1;
				luma_crc_q <= `CRC_ZERO; // see RQ11
				chroma_crc_q <= `CRC_ZERO;
			end
			else if (crc_run_q)
			begin
				// the CRC sees the formatted word, so inserted line words are covered
				luma_crc_q <= crc_word(luma_crc_q, fmt[19:10]); // see RQ9 see RQ10
				chroma_crc_q <= crc_word(chroma_crc_q, fmt[9:0]);
				if (ins && seq_q == `SEQ_LINE_SECOND)
					crc_run_q <= 1'b0; // see RQ10
			end
		end
	end

	// two-entry output buffer: head drives the port, spare absorbs one stall
	reg [19:0] spare_q;
	reg spare_valid_q;
	reg [19:0] head_d;
	reg head_valid_d;
	reg [19:0] spare_d;
	reg spare_valid_d;
	wire pop = coded_valid_q & coded_ready;

	always @*
	begin
		head_d = coded_out_q;
		head_valid_d = coded_valid_q;
		spare_d = spare_q;
		spare_valid_d = spare_valid_q;
		if (pop)
		begin
			if (spare_valid_q)
			begin
				head_d = spare_q;
				spare_valid_d = accept;
				if (accept)
					spare_d = coded[19:0];
			end
			else
			begin
				head_valid_d = accept;
				if (accept)
					head_d = coded[19:0];
			end
		end
		else if (accept)
		begin
			if (!coded_valid_q)
			begin
				head_d = coded[19:0];
				head_valid_d = 1'b1;
			end
			else
			begin
				spare_d = coded[19:0];
				spare_valid_d = 1'b1;
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			coded_out_q <= 20'h00000;
			coded_valid_q <= 1'b0;
			spare_q <= 20'h00000;
			spare_valid_q <= 1'b0;
			video_ready_q <= 1'b0;
		end
		else
		begin
			coded_out_q <= head_d;
			coded_valid_q <= head_valid_d;
			spare_q <= spare_d;
			spare_valid_q <= spare_valid_d;
			// ready is registered, so the spare entry must be free next cycle
			video_ready_q <= ~spare_valid_d;
		end
	end

	// alternate reference clock watch; only meaningful when the clock is slower than clk_sys
	reg alt_s1_q;
	reg alt_s2_q;
	reg alt_s3_q;
	reg alt_lvl_q;
	reg [7:0] alt_idle_q;
	reg [1:0] alt_fill_q;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alt_s1_q <= 1'b0;
			alt_s2_q <= 1'b0;
			alt_s3_q <= 1'b0;
			alt_lvl_q <= 1'b0;
			alt_idle_q <= 8'h00;
			alt_fill_q <= 2'h0;
			ref_clock_select_q <= 1'b0;
		end
		else
		begin
			alt_s1_q <= alt_serial_ref_clock;
			alt_s2_q <= alt_s1_q;
			alt_s3_q <= alt_s2_q;
			// the first settled level after reset is taken as it is, never as an edge
			if (alt_fill_q != 2'h3)
			begin
				alt_fill_q <= alt_fill_q + 2'h1;
				alt_lvl_q <= alt_s2_q;
			end
			else if (alt_s2_q == alt_s3_q)
				alt_lvl_q <= alt_s3_q;
			if (alt_fill_q == 2'h3 && alt_s2_q == alt_s3_q && alt_s3_q != alt_lvl_q)
				alt_idle_q <= `ALT_IDLE_CYCLES;
			else if (alt_idle_q != 8'h00)
				alt_idle_q <= alt_idle_q - 8'h01;
			// switch only to a running clock, and never when the option is off
			ref_clock_select_q <= (RATE_SWITCH_EN != 0) && rate_family_sel && (alt_idle_q != 8'h00); // see RQ16
		end
	end

endmodule
`default_nettype wire

// ### hw/sdi_tx_consts.vh
// constants for the sdi transmit formatter and channel coder
// How it works
// RQ1: video word is 20 bits HD, 10 bits SD
// RQ2: luma upper bits, chroma lower bits; SD lower only
// RQ3: HD lines get line number and CRC
// RQ4: only low 11 line-number bits are used
// RQ5: line words follow the EAV XYZ word
// RQ6: same line number in luma and chroma
// RQ7: source marks first word of EAV and SAV
// RQ8: two CRC words per channel follow line words
// RQ9: separate luma and chroma CRC engines
// RQ10: CRC spans first active word to second line word
// RQ11: CRC starts at zero, poly x18+x5+x4+1
// RQ12: CRC advances bit serially, LSB first
// RQ13: scramble x9+x4+1 then NRZI x+1, SD and HD
// RQ14: scrambler handles 10 or 20 bit words
// RQ15: coding bit serial, LSB first, state carried over
// RQ16: alternate reference clock only when switching enabled
// RQ17: CRC low bits go in the first word
// RQ18: SD bypasses line and CRC insertion
`ifndef SDI_TX_CONSTS_VH
`define SDI_TX_CONSTS_VH

// word index after the trs marker word
`define SEQ_IDLE 3'h0
`define SEQ_XYZ 3'h3
`define SEQ_LINE_FIRST 3'h4
`define SEQ_LINE_SECOND 3'h5
`define SEQ_CRC_FIRST 3'h6
`define SEQ_CRC_SECOND 3'h7

// H bit of the luma XYZ word: set on EAV, clear on SAV
`define XYZ_H_BIT 16

// CRC and scrambler geometry
`define CRC_WIDTH 18
`define CRC_ZERO 18'h00000
`define SCR_ZERO 9'h000

// alternate reference clock is seen as stopped after this many quiet cycles
`define ALT_IDLE_CYCLES 8'hff

`endif

// ### verification/serial_sink.sv
// serializer-side sink that can stall the coded stream
`timescale 1ns/1ps
`default_nettype none
module serial_sink (
	// clock
	input wire logic clk_sys,
	// stall request
	input wire logic stall,
	// handshake
	output logic coded_ready = 1'b0
);
	always @(posedge clk_sys)
		coded_ready <= !stall;
endmodule
`default_nettype wire

// ### verification/sdi_tx_chk.sv
// port checker for the sdi transmit formatter
`timescale 1ns/1ps
`default_nettype none
module sdi_tx_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// streams
	input wire logic hd_mode,
	input wire logic video_valid,
	input wire logic video_ready_q,
	input wire logic [19:0] coded_out_q,
	input wire logic coded_valid_q,
	input wire logic coded_ready,
	// reference clock choice
	input wire logic rate_family_sel,
	input wire logic ref_clock_select_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_HOLD:
	assert property (coded_valid_q && !coded_ready |=> coded_valid_q && $stable(coded_out_q)) else $error("word lost");
	AST_ANSWER:
	assert property (video_valid && video_ready_q && !coded_valid_q |=> coded_valid_q) else $error("no answer");
	AST_NOLOSS:
	assert property (video_valid && video_ready_q && coded_valid_q && !coded_ready |=> coded_valid_q[*2]) else
		$error("spare lost");
	AST_SD_UPPER:
	assert property (!hd_mode && !$past(hd_mode, 3) && coded_valid_q |-> coded_out_q[19:10] == 10'h000) else
		$error("sd upper");
	AST_REFSEL:
	assert property (ref_clock_select_q |-> $past(rate_family_sel)) else $error("ref select");
	AST_REFSEL_OFF:
	assert property (!rate_family_sel |=> !ref_clock_select_q) else $error("ref select off");
	AST_RELEASE:
	assert property ($rose(reset_n) |-> !video_ready_q[*2]) else $error("early ready");
	AST_REFILL:
	assert property (!video_ready_q && coded_valid_q && coded_ready |-> ##[1:2] video_ready_q) else $error("no refill");
	AST_FULL:
	assert property (coded_valid_q && !coded_ready && !video_ready_q |=> !video_ready_q) else $error("overfill");
endmodule
bind sdi_tx_formatter_scrambler sdi_tx_chk sdi_tx_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
	.hd_mode(hd_mode), .video_valid(video_valid), .video_ready_q(video_ready_q), .coded_out_q(coded_out_q),
	.coded_valid_q(coded_valid_q), .coded_ready(coded_ready), .rate_family_sel(rate_family_sel),
	.ref_clock_select_q(ref_clock_select_q));
`default_nettype wire

// ### verification/tb_top.sv
// bench for the sdi transmit formatter and channel coder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
	logic clk_sys = 0, reset_n = 0, hd_mode = 0, video_valid = 0, trs_marker = 0, stall = 0, p = 0;
	logic [19:0] video_in = 0, e;
	logic [15:0] line_number_in = 0;
	logic video_ready_q, coded_valid_q, coded_ready;
	logic ref_clock_select_q, rate_family_sel = 0, alt_run = 1;
	logic [3:0] alt_div = 0;
	logic [19:0] coded_out_q;
	logic [8:0] s = 0;
	logic [17:0] cy, cc;
	logic [19:0] exq[$];
	int errors = 0, compares = 0, cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	sdi_tx_formatter_scrambler #(.RATE_SWITCH_EN(1)) sdi_tx_formatter_scrambler_inst (.clk_sys(clk_sys),
		.reset_n(reset_n),
		.hd_mode(hd_mode), .video_in(video_in), .video_valid(video_valid), .trs_marker(trs_marker),
		.line_number_in(line_number_in), .video_ready_q(video_ready_q), .coded_out_q(coded_out_q),
		.coded_valid_q(coded_valid_q), .coded_ready(coded_ready), .alt_serial_ref_clock(alt_div[3]),
		.rate_family_sel(rate_family_sel), .ref_clock_select_q(ref_clock_select_q));
	serial_sink serial_sink_inst (.clk_sys(clk_sys), .stall(stall), .coded_ready(coded_ready));
	// slow alternate reference clock, one edge every 8 cycles, stopped by alt_run
	always @(posedge clk_sys)
		if (alt_run)
			alt_div <= alt_div + 4'h1;
	function automatic [17:0] crc10(input [17:0] c, input [9:0] d);
		logic f;
		for (int i = 0; i < 10; i++)
		begin
			f = c[0] ^ d[i];
			c = {f, c[17:1]};
			c[13] ^= f;
			c[12] ^= f;
		end
		return c;
	endfunction
	// ready is read at the falling edge so the taking edge is judged on settled values
	task automatic put(input [19:0] w, input t, input [19:0] x);
		logic r;
		logic [19:0] o;
		int n;
		n = 0;
		o = 0;
		video_valid <= 1;
		video_in <= w;
		trs_marker <= t;
		do
		begin
			@(negedge clk_sys);
			r = video_ready_q;
			@(posedge clk_sys);
			n++;
		end while (r !== 1 && n < 50);
		for (int i = 0; i < (hd_mode ? 20 : 10); i++)
		begin
			s = {s[7:0], x[i] ^ s[8] ^ s[3]};
			p = p ^ s[0];
			o[i] = p;
		end
		exq.push_back(o);
	endtask
	task automatic drain(input string m);
		video_valid <= 0;
		repeat (8) @(posedge clk_sys);
		`CHK("left", 0, exq.size())
		$display("%s done", m);
	endtask
	task automatic sd_test();
		logic [19:0] w;
		stall <= 1;
		for (int i = 0; i < 10; i++)
		begin
			w = i == 0 ? 20'hfffff : i == 3 ? 20'hbb274 : i < 3 ? 20'hab000 : {10'h2c5, 10'h0f0 + i[9:0]};
			put(w, i == 0, w);
			if (i == 1)
			begin
				video_valid <= 0;
				repeat (4) @(posedge clk_sys);
				`CHK("ready", 1'b0, video_ready_q)
				stall <= 0;
			end
		end
		drain("sd");
	endtask
	task automatic hd_test();
		logic [19:0] x;
		logic [9:0] a, b;
		a = {1'b1, 7'h23, 2'b00};
		b = {1'b1, 3'b000, 4'hb, 2'b00};
		cy = 0;
		cc = 0;
		line_number_in <= 16'hf5a3;
		hd_mode <= 1;
		for (int i = 0; i < 16; i++)
		begin
			case (i)
				0, 8: x = 20'hfffff;
				3: x = {2{10'h200}};
				11: x = {2{10'h274}};
				12: x = {a, a};
				13: x = {b, b};
				14: x = {~cy[8], cy[8:0], ~cc[8], cc[8:0]};
				15: x = {~cy[17], cy[17:9], ~cc[17], cc[17:9]};
				default: x = (i > 3 && i < 8) ? {10'h040 + i[9:0], 10'h1a0 + i[9:0]} : 20'h0;
			endcase
			if (i > 3 && i < 14)
			begin
				cy = crc10(cy, x[19:10]);
				cc = crc10(cc, x[9:0]);
			end
			put(i > 11 ? 20'h5a5a5 : x, i == 0 || i == 8, x);
		end
		drain("hd");
	endtask
	task automatic ref_test();
		rate_family_sel <= 1;
		repeat (40) @(posedge clk_sys);
		`CHK("refsel on", 1'b1, ref_clock_select_q)
		rate_family_sel <= 0;
		repeat (2) @(posedge clk_sys);
		`CHK("refsel off", 1'b0, ref_clock_select_q)
		rate_family_sel <= 1;
		alt_run <= 0;
		repeat (300) @(posedge clk_sys);
		`CHK("refsel stop", 1'b0, ref_clock_select_q)
		$display("ref done");
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (coded_valid_q === 1 && coded_ready === 1)
		begin
			e = exq.size() ? exq.pop_front() : 20'hxxxxx;
			`CHK("coded", e, coded_out_q)
		end
		if (cyc == 3000)
		begin
			errors++;
			summarize();
		end
	end
	initial
	begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1;
		repeat (4) @(posedge clk_sys);
		sd_test();
		hd_test();
		ref_test();
		summarize();
	end
endmodule
`default_nettype wire
